//--- logic/smc_defs.svh
// Constants of the supply mode and cutoff controller
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

`define SMC_CLK_HZ      250_000_000
`define SMC_BAUD        9600
`define SMC_STAT_MS     500
`define SMC_REG_US      1000
`define SMC_LOWI_MA     16'h0064
`define SMC_VSTEP       16'h0001
`define SMC_PKT_PT      8'hC8
`define SMC_PKT_ADDR    8'h55
`define SMC_TBL_LEN     7'h44
`define SMC_PKT_LEN     7'h19

`define SMC_A_CTRL      6'h00
`define SMC_A_STATUS    6'h01
`define SMC_A_IRQ_STAT  6'h02
`define SMC_A_IRQ_MASK  6'h03
`define SMC_A_VOUT0     6'h04
`define SMC_A_ILIM0     6'h08

`define SMC_CTRL_EN     2:0
`define SMC_CTRL_EXEMPT 5:3
`define SMC_CTRL_LOWI   8:6
`define SMC_CTRL_CUTEN  9
`define SMC_CTRL_THR    31:16

`define SMC_IRQ_BIN     0
`define SMC_IRQ_TXT     1
`define SMC_IRQ_CUT     2
`define SMC_IRQ_CREG    3

`define SMC_RST_VTGT    16'h01F4
`define SMC_RST_ILIM    16'h09C4

`endif

//--- logic/smc_pkg.sv
// Types of the supply mode and cutoff controller
`include "smc_defs.svh"
package smc_pkg;
  typedef enum logic [1:0] {SMC_OFF, SMC_VOLTAGE_REGULATING, SMC_CURRENT_REGULATING} smc_chst_t;
  typedef enum logic [1:0] {SMC_RX_IDLE, SMC_RX_START, SMC_RX_DATA, SMC_RX_STOP} smc_rx_t;
  typedef enum logic [1:0] {SMC_MSG_IDLE, SMC_MSG_TABLE, SMC_MSG_PKT} smc_msg_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } smc_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } smc_ahb_rsp_t;

  typedef struct packed {
    logic [15:0]      vin;
    logic [2:0][15:0] vout;
    logic [2:0][15:0] iout;
  } smc_meas_t;

  typedef struct packed {
    logic             mode_bin;
    logic [1:0]       match;
    logic             rx_s1;
    logic             rx_s2;
    smc_rx_t          rx_st;
    logic [15:0]      rx_cnt;
    logic [2:0]       rx_bit;
    logic [7:0]       rx_sh;
    logic             tx_busy;
    logic [15:0]      tx_cnt;
    logic [3:0]       tx_bit;
    logic [9:0]       tx_sh;
    logic             tx_line;
    smc_msg_t         msg;
    logic [6:0]       msg_idx;
    logic [15:0]      csum;
    logic [26:0]      stat_tmr;
    logic [19:0]      reg_tmr;
    logic [31:0]      cmd_word;
    logic [1:0]       cmd_chan;
    logic [15:0]      cmd_val;
    logic [1:0]       cmd_frac;
    logic             cmd_dot;
    logic             cmd_arg;
    logic [2:0]       en;
    logic [2:0]       exempt;
    logic [2:0]       lowi;
    logic             cut_en;
    logic [15:0]      cut_thr;
    logic             cutoff;
    logic [2:0]       out_en;
    logic [2:0][15:0] vtgt;
    logic [2:0][15:0] ilim;
    logic [2:0][15:0] vset;
    smc_chst_t [2:0]  chst;
    logic [3:0]       irq_st;
    logic [3:0]       irq_mask;
    logic             irq;
    logic             ahb_wr;
    logic [5:0]       ahb_idx;
    logic [31:0]      hrdata;
    logic             hready;
  } smc_st_t;
endpackage

//--- logic/smc_ctrl.sv
// Supply mode switching, serial status, cutoff and current regulation
`include "smc_defs.svh"
module smc_ctrl #(
  parameter int BAUD_DIV = `SMC_CLK_HZ / `SMC_BAUD,
  parameter int STAT_DIV = (`SMC_CLK_HZ / 1000) * `SMC_STAT_MS,
  parameter int REG_DIV  = (`SMC_CLK_HZ / 1_000_000) * `SMC_REG_US
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire smc_pkg::smc_ahb_req_t ahb_req,
  output smc_pkg::smc_ahb_rsp_t      ahb_rsp,
  input  wire logic                  uart_rx,
  output logic                       uart_tx,
  input  wire smc_pkg::smc_meas_t    meas,
  output logic [2:0]                 out_en,
  output logic [2:0][15:0]           out_vset,
  output smc_pkg::smc_chst_t [2:0]   out_state,
  output logic                       sleep,
  output logic                       irq
);
  if (BAUD_DIV < 16 || BAUD_DIV > 65535) $error("BAUD_DIV out of range");
  if (STAT_DIV < 2 || STAT_DIV > 134217727) $error("STAT_DIV out of range");
  if (REG_DIV < 2 || REG_DIV > 1048575) $error("REG_DIV out of range");

  localparam logic [15:0] BDIV  = 16'(BAUD_DIV - 1);
  localparam logic [15:0] BHALF = 16'(BAUD_DIV / 2);
  localparam logic [26:0] SDIV  = 27'(STAT_DIV - 1);
  localparam logic [19:0] RDIV  = 20'(REG_DIV - 1);

  smc_pkg::smc_st_t q;
  smc_pkg::smc_st_t d;

  function automatic logic [7:0] hexc(input logic [15:0] v, input int k);
    logic [3:0] n;
    n = 4'(v >> (4 * (3 - k)));
    return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction

  function automatic logic [7:0] stc(input smc_pkg::smc_chst_t s);
    case (s)
      smc_pkg::SMC_VOLTAGE_REGULATING: return 8'h56;
      smc_pkg::SMC_CURRENT_REGULATING: return 8'h43;
      default:                         return 8'h4F;
    endcase
  endfunction

  // Readable table: header line plus one 20-byte line per output
  function automatic logic [7:0] tbl_byte(input smc_pkg::smc_st_t s, input smc_pkg::smc_meas_t m,
                                          input logic [6:0] idx);
    logic [6:0] rel;
    int         ch;
    int         p;
    rel = idx - 7'h08;
    ch  = int'(rel) / 20;
    p   = int'(rel) % 20;
    if (idx < 7'h08) begin
      case (idx)
        7'h00:   return 8'h49;
        7'h01:   return 8'h20;
        7'h06:   return 8'h0D;
        7'h07:   return 8'h0A;
        default: return hexc(m.vin, int'(idx) - 2);
      endcase
    end
    if (ch > 2) begin
      return 8'h20;
    end
    case (p)
      0:       return 8'h31 + 8'(ch);
      1, 6,
      16:      return 8'h20;
      2, 3,
      4, 5:    return hexc(m.vout[ch], p - 2);
      7, 8,
      9, 10:   return hexc(m.iout[ch], p - 7);
      11:      return 8'h2F;
      12, 13,
      14, 15:  return hexc(s.ilim[ch], p - 12);
      17:      return stc(s.chst[ch]);
      18:      return 8'h0D;
      default: return 8'h0A;
    endcase
  endfunction

  // Status packet: start sequence, type, address, data, checksum
  function automatic logic [7:0] pkt_byte(input smc_pkg::smc_st_t s, input smc_pkg::smc_meas_t m,
                                          input logic [6:0] idx);
    int ch;
    int p;
    ch = (int'(idx) - 7) / 5;
    p  = (int'(idx) - 7) % 5;
    case (idx)
      7'h00: return 8'h73;
      7'h01: return 8'h6E;
      7'h02: return 8'h70;
      7'h03: return `SMC_PKT_PT;
      7'h04: return `SMC_PKT_ADDR;
      7'h05: return m.vin[15:8];
      7'h06: return m.vin[7:0];
      7'h16: return {2'h0, s.exempt, s.cutoff, s.mode_bin, s.cut_en};
      7'h17: return s.csum[15:8];
      7'h18: return s.csum[7:0];
      default: begin
        if (ch > 2) begin
          return 8'h00;
        end
        case (p)
          0:       return m.vout[ch][15:8];
          1:       return m.vout[ch][7:0];
          2:       return m.iout[ch][15:8];
          3:       return m.iout[ch][7:0];
          default: return {6'h00, s.chst[ch]};
        endcase
      end
    endcase
  endfunction

  always_comb begin
    logic        rx_done;
    logic [7:0]  b;
    logic [7:0]  txb;
    logic        rd;
    logic [31:0] rdat;
    logic [3:0]  ev;
    logic [31:0] sc;
    logic [15:0] lim;
    logic [1:0]  nch;
    d       = q;
    rx_done = 1'b0;
    b       = q.rx_sh;
    txb     = 8'h00;
    rd      = 1'b0;
    rdat    = 32'h0000_0000;
    ev      = 4'h0;
    sc      = 32'h0000_0000;
    lim     = 16'h0000;
    nch     = 2'h0;

    // Receiver, 8N1, mid-bit sampling
    d.rx_s1 = uart_rx;
    d.rx_s2 = q.rx_s1;
    d.rx_cnt = q.rx_cnt + 16'h0001;
    case (q.rx_st)
      smc_pkg::SMC_RX_IDLE: begin
        d.rx_cnt = 16'h0000;
        if (!q.rx_s2) begin
          d.rx_st = smc_pkg::SMC_RX_START;
        end
      end
      smc_pkg::SMC_RX_START: begin
        if (q.rx_cnt == BHALF) begin
          d.rx_cnt = 16'h0000;
          d.rx_bit = 3'h0;
          d.rx_st  = q.rx_s2 ? smc_pkg::SMC_RX_IDLE : smc_pkg::SMC_RX_DATA;
        end
      end
      smc_pkg::SMC_RX_DATA: begin
        if (q.rx_cnt == BDIV) begin
          d.rx_cnt = 16'h0000;
          d.rx_sh  = {q.rx_s2, q.rx_sh[7:1]};
          d.rx_bit = q.rx_bit + 3'h1;
          if (q.rx_bit == 3'h7) begin
            d.rx_st = smc_pkg::SMC_RX_STOP;
          end
        end
      end
      default: begin
        if (q.rx_cnt == BDIV) begin
          d.rx_st = smc_pkg::SMC_RX_IDLE;
          rx_done = q.rx_s2;
        end
      end
    endcase

    if (rx_done) begin
      // Sequence matcher; a stray byte restarts it
      d.match = (b == 8'h3A) ? 2'h1 : 2'h0;
      if (q.match == 2'h1 && !q.mode_bin && b == 8'h62) begin
        d.match = 2'h2;
      end
      if (q.match == 2'h1 && q.mode_bin && b == 8'h78) begin
        d.mode_bin      = 1'b0;
        ev[`SMC_IRQ_TXT] = 1'b1;
      end
      if (q.match == 2'h2 && b == 8'h0D) begin
        d.mode_bin      = 1'b1;
        d.stat_tmr      = 27'h000_0000;
        ev[`SMC_IRQ_BIN] = 1'b1;
      end
      // Text command line parser, alive during sleep
      if (!q.mode_bin) begin
        if (b == 8'h0D) begin
          case (q.cmd_frac)
            2'h0:    sc = 32'(q.cmd_val) * 32'd100;
            2'h1:    sc = 32'(q.cmd_val) * 32'd10;
            default: sc = 32'(q.cmd_val);
          endcase
          nch = 2'(q.cmd_val - 16'h0001);
          if (q.cmd_word == 32'h0073_6574 && q.cmd_chan != 2'h3) begin
            d.vtgt[q.cmd_chan] = sc[15:0];
          end
          if (q.cmd_word == 32'h7365_7463 && q.cmd_chan != 2'h3) begin
            d.ilim[q.cmd_chan] = 16'(sc * 32'd10);
          end
          if (q.cmd_val >= 16'h0001 && q.cmd_val <= 16'h0003 && q.cmd_word == 32'h0000_656E) begin
            d.en[nch] = 1'b1;
          end
          if (q.cmd_val >= 16'h0001 && q.cmd_val <= 16'h0003 && q.cmd_word == 32'h0064_6973) begin
            d.en[nch] = 1'b0;
          end
          d.cmd_word = 32'h0000_0000;
          d.cmd_chan = 2'h3;
          d.cmd_val  = 16'h0000;
          d.cmd_frac = 2'h0;
          d.cmd_dot  = 1'b0;
          d.cmd_arg  = 1'b0;
          if (q.match != 2'h2 && q.msg == smc_pkg::SMC_MSG_IDLE) begin
            d.msg     = smc_pkg::SMC_MSG_TABLE;
            d.msg_idx = 7'h00;
          end
        end else if (b == 8'h20) begin
          d.cmd_arg = 1'b1;
        end else if (b == 8'h2E) begin
          d.cmd_dot = 1'b1;
        end else if (b >= 8'h30 && b <= 8'h39) begin
          if (!q.cmd_arg) begin
            d.cmd_chan = (b >= 8'h31 && b <= 8'h33) ? 2'(b - 8'h31) : 2'h3;
          end else if (!(q.cmd_dot && q.cmd_frac == 2'h2)) begin
            d.cmd_val = 16'(32'(q.cmd_val) * 32'd10 + 32'(b - 8'h30));
            if (q.cmd_dot) begin
              d.cmd_frac = q.cmd_frac + 2'h1;
            end
          end
        end else if (!q.cmd_arg) begin
          d.cmd_word = {q.cmd_word[23:0], b};
        end
      end
    end

    // Periodic status packet in binary mode
    d.stat_tmr = (q.stat_tmr == SDIV || !q.mode_bin) ? 27'h000_0000 : q.stat_tmr + 27'h000_0001;
    if (q.mode_bin && q.stat_tmr == SDIV && q.msg == smc_pkg::SMC_MSG_IDLE) begin
      d.msg     = smc_pkg::SMC_MSG_PKT;
      d.msg_idx = 7'h00;
      d.csum    = 16'h0000;
    end

    // Transmitter, LSB first, idle high
    if (q.tx_busy) begin
      d.tx_cnt = q.tx_cnt + 16'h0001;
      if (q.tx_cnt == BDIV) begin
        d.tx_cnt  = 16'h0000;
        d.tx_sh   = {1'b1, q.tx_sh[9:1]};
        d.tx_line = q.tx_sh[1];
        d.tx_bit  = q.tx_bit + 4'h1;
        if (q.tx_bit == 4'h9) begin
          d.tx_busy = 1'b0;
          d.tx_line = 1'b1;
        end
      end
    end else if (q.msg != smc_pkg::SMC_MSG_IDLE) begin
      txb       = (q.msg == smc_pkg::SMC_MSG_PKT) ? pkt_byte(q, meas, q.msg_idx) : tbl_byte(q, meas, q.msg_idx);
      d.tx_sh   = {1'b1, txb, 1'b0};
      d.tx_line = 1'b0;
      d.tx_busy = 1'b1;
      d.tx_cnt  = 16'h0000;
      d.tx_bit  = 4'h0;
      d.csum    = (q.msg_idx < 7'h17) ? q.csum + {8'h00, txb} : q.csum;
      d.msg_idx = q.msg_idx + 7'h01;
      if (q.msg_idx == ((q.msg == smc_pkg::SMC_MSG_PKT) ? `SMC_PKT_LEN : `SMC_TBL_LEN) - 7'h01) begin
        d.msg = smc_pkg::SMC_MSG_IDLE;
      end
    end

    // Latched low input cutoff
    if (q.cut_en && meas.vin < q.cut_thr && !q.cutoff) begin
      d.cutoff         = 1'b1;
      ev[`SMC_IRQ_CUT] = 1'b1;
    end
    d.out_en = q.en & ~({3{q.cutoff}} & ~q.exempt);

    // Slow current limit loop per output
    d.reg_tmr = (q.reg_tmr == RDIV) ? 20'h0_0000 : q.reg_tmr + 20'h0_0001;
    for (int i = 0; i < 3; i++) begin
      lim = (q.lowi[i] && q.ilim[i] > `SMC_LOWI_MA) ? `SMC_LOWI_MA : q.ilim[i];
      if (!q.out_en[i]) begin
        d.vset[i] = q.vtgt[i];
        d.chst[i] = smc_pkg::SMC_OFF;
      end else if (q.reg_tmr == RDIV) begin
        if (meas.iout[i] > lim) begin
          d.vset[i] = (q.vset[i] > `SMC_VSTEP) ? q.vset[i] - `SMC_VSTEP : 16'h0000;
          d.chst[i] = smc_pkg::SMC_CURRENT_REGULATING;
        end else if (q.vset[i] < q.vtgt[i]) begin
          d.vset[i] = q.vset[i] + `SMC_VSTEP;
          d.chst[i] = smc_pkg::SMC_CURRENT_REGULATING;
        end else begin
          d.vset[i] = q.vtgt[i];
          d.chst[i] = smc_pkg::SMC_VOLTAGE_REGULATING;
        end
      end else if (q.chst[i] == smc_pkg::SMC_OFF) begin
        d.chst[i] = smc_pkg::SMC_VOLTAGE_REGULATING;
      end
      if (d.chst[i] == smc_pkg::SMC_CURRENT_REGULATING && q.chst[i] != smc_pkg::SMC_CURRENT_REGULATING) begin
        ev[`SMC_IRQ_CREG] = 1'b1;
      end
    end

    // Bus slave, zero wait states
    d.hready = 1'b1;
    d.ahb_wr = 1'b0;
    if (ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1]) begin
      d.ahb_wr  = ahb_req.hwrite;
      d.ahb_idx = ahb_req.haddr[7:2];
      rd        = !ahb_req.hwrite;
    end
    case (ahb_req.haddr[7:2])
      `SMC_A_CTRL:     rdat = {q.cut_thr, 6'h00, q.cut_en, q.lowi, q.exempt, q.en};
      `SMC_A_STATUS:   rdat = {21'h00_0000, q.chst, q.out_en, q.cutoff, q.mode_bin};
      `SMC_A_IRQ_STAT: rdat = {28'h000_0000, q.irq_st};
      `SMC_A_IRQ_MASK: rdat = {28'h000_0000, q.irq_mask};
      6'h04, 6'h05,
      6'h06:           rdat = {q.vset[ahb_req.haddr[3:2]], q.vtgt[ahb_req.haddr[3:2]]};
      6'h08, 6'h09,
      6'h0A:           rdat = {meas.iout[ahb_req.haddr[3:2]], q.ilim[ahb_req.haddr[3:2]]};
      default:         rdat = 32'h0000_0000;
    endcase
    d.hrdata = rd ? rdat : q.hrdata;
    if (q.ahb_wr) begin
      case (q.ahb_idx)
        `SMC_A_CTRL: begin
          d.en      = ahb_req.hwdata[`SMC_CTRL_EN];
          d.exempt  = ahb_req.hwdata[`SMC_CTRL_EXEMPT];
          d.lowi    = ahb_req.hwdata[`SMC_CTRL_LOWI];
          d.cut_en  = ahb_req.hwdata[`SMC_CTRL_CUTEN];
          d.cut_thr = ahb_req.hwdata[`SMC_CTRL_THR];
        end
        `SMC_A_IRQ_MASK: d.irq_mask = ahb_req.hwdata[3:0];
        6'h04, 6'h05,
        6'h06:           d.vtgt[q.ahb_idx[1:0]] = ahb_req.hwdata[15:0];
        6'h08, 6'h09,
        6'h0A:           d.ilim[q.ahb_idx[1:0]] = ahb_req.hwdata[15:0];
        default:         d.irq_mask = q.irq_mask;
      endcase
    end

    // Read clears status; a new event wins
    d.irq_st = ((rd && ahb_req.haddr[7:2] == `SMC_A_IRQ_STAT) ? 4'h0 : q.irq_st) | ev;
    d.irq    = |(d.irq_st & d.irq_mask);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q          <= '0;
      q.mode_bin <= 1'b0;
      q.rx_s1    <= 1'b1;
      q.rx_s2    <= 1'b1;
      q.tx_line  <= 1'b1;
      q.tx_sh    <= 10'h3FF;
      q.cmd_chan <= 2'h3;
      q.vtgt     <= {3{`SMC_RST_VTGT}};
      q.vset     <= {3{`SMC_RST_VTGT}};
      q.ilim     <= {3{`SMC_RST_ILIM}};
      q.hready   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign ahb_rsp   = '{hrdata: q.hrdata, hreadyout: q.hready, hresp: q.irq & 1'b0};
  assign uart_tx   = q.tx_line;
  assign out_en    = q.out_en;
  assign out_vset  = q.vset;
  assign out_state = q.chst;
  assign sleep     = q.cutoff;
  assign irq       = q.irq;
endmodule

//--- verif/smc_ctrl_asserts.sv
// Port checker for the supply mode and cutoff controller
module smc_ctrl_asserts #(
  parameter int BAUD_DIV = 16,
  parameter int STAT_DIV = 6000,
  parameter int REG_DIV  = 50
) (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire smc_pkg::smc_ahb_rsp_t ahb_rsp,
  input wire logic                  uart_tx,
  input wire logic [2:0]            out_en,
  input wire logic [2:0][15:0]      out_vset,
  input wire smc_pkg::smc_chst_t [2:0] out_state,
  input wire logic                  sleep
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [15:0] low_q;
  // Length of the current low run on tx
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low_q <= 16'h0000;
    end else begin
      low_q <= uart_tx ? 16'h0000 : low_q + 16'h0001;
    end
  end
  property p_tx_bit_len;
    $rose(uart_tx) |-> (int'(low_q) % BAUD_DIV) == 0;
  endproperty
  a_tx_bit_len: assert property (p_tx_bit_len) else $error("tx low run not whole bits");
  property p_tx_max_low;
    int'(low_q) <= 9 * BAUD_DIV;
  endproperty
  a_tx_max_low: assert property (p_tx_max_low) else $error("tx low beyond one frame");
  property p_sleep_hold;
    sleep |=> sleep;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep released");
  property p_rsp_okay;
    ahb_rsp.hreadyout && !ahb_rsp.hresp;
  endproperty
  a_rsp_okay: assert property (p_rsp_okay) else $error("bus answer not ready okay");
  property p_vset_step;
    out_en[0] && $past(out_en[0]) && $changed(out_vset[0]) |->
      (out_vset[0] - $past(out_vset[0]) == 16'h0001) || ($past(out_vset[0]) - out_vset[0] == 16'h0001);
  endproperty
  a_vset_step: assert property (p_vset_step) else $error("vset jumped");
  property p_vset_slow;
    out_en[0] && $changed(out_vset[0]) |=> $stable(out_vset[0]) [*8];
  endproperty
  a_vset_slow: assert property (p_vset_slow) else $error("vset loop too fast");
  property p_state_legal;
    out_state[0] != 2'd3 && out_state[1] != 2'd3 && out_state[2] != 2'd3;
  endproperty
  a_state_legal: assert property (p_state_legal) else $error("illegal channel state");
  property p_state_off;
    !out_en[1] [*3] |-> out_state[1] == smc_pkg::SMC_OFF;
  endproperty
  a_state_off: assert property (p_state_off) else $error("disabled channel not off");
  property p_en_volt;
    $rose(out_en[0]) |-> ##[0:2] out_state[0] == smc_pkg::SMC_VOLTAGE_REGULATING;
  endproperty
  a_en_volt: assert property (p_en_volt) else $error("enabled channel not regulating");
  c_sleep: cover property ($rose(sleep));
  c_creg: cover property (out_state[0] == smc_pkg::SMC_CURRENT_REGULATING);
  c_frame: cover property ($rose(uart_tx));
endmodule

bind smc_ctrl smc_ctrl_asserts #(.BAUD_DIV(BAUD_DIV), .STAT_DIV(STAT_DIV), .REG_DIV(REG_DIV)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .ahb_rsp(ahb_rsp), .uart_tx(uart_tx), .out_en(out_en),
  .out_vset(out_vset), .out_state(out_state), .sleep(sleep));

//--- verif/smc_host.sv
// Serial host model: sends typed bytes and collects replies
module smc_host #(
  parameter int BAUD_DIV = 16
) (
  input  wire logic sys_clk,
  input  wire logic uart_tx,
  output logic      uart_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rxq[$];
  int         bad_stop = 0;
  initial uart_rx = 1'b1; // Idle high between frames
  task automatic put(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0}; // 8N1, LSB first
    for (int i = 0; i < 10; i++) begin
      uart_rx <= f[i];
      repeat (BAUD_DIV) @(posedge sys_clk);
    end
  endtask
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge uart_tx);
      repeat (BAUD_DIV / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BAUD_DIV) @(posedge sys_clk);
        b[i] = uart_tx;
      end
      repeat (BAUD_DIV) @(posedge sys_clk);
      if (uart_tx !== 1'b1) bad_stop++;
      rxq.push_back(b);
    end
  end
endmodule

//--- verif/tb_top.sv
// Self-checking bench for the supply mode and cutoff controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BD = 16;
  localparam int SD = 6000;
  logic                     sys_clk, rst, uart_rx, uart_tx, sleep, irq;
  smc_pkg::smc_ahb_req_t    req;
  smc_pkg::smc_ahb_rsp_t    rsp;
  smc_pkg::smc_meas_t       meas;
  logic [2:0]               out_en;
  logic [2:0][15:0]         out_vset;
  smc_pkg::smc_chst_t [2:0] out_state;
  logic [31:0]              rd;
  logic [15:0]              v1, sum;
  int                       bad_count = 0, n_compared = 0, cyc = 0, t1, m_ctrl;
  smc_ctrl #(.BAUD_DIV(BD), .STAT_DIV(SD), .REG_DIV(50)) DUT (
    .sys_clk(sys_clk), .rst(rst), .ahb_req(req), .ahb_rsp(rsp), .uart_rx(uart_rx), .uart_tx(uart_tx),
    .meas(meas), .out_en(out_en), .out_vset(out_vset), .out_state(out_state), .sleep(sleep), .irq(irq));
  smc_host #(.BAUD_DIV(BD)) host (.sys_clk(sys_clk), .uart_tx(uart_tx), .uart_rx(uart_rx));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @* req.hready = rsp.hreadyout;
  task automatic end_sim();
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 100000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    req.htrans <= 2'b10;
    req.haddr <= {24'h0000_00, a};
    req.hwrite <= w;
    do @(posedge sys_clk); while (rsp.hreadyout !== 1'b1);
    req.htrans <= 2'b00;
    req.hwdata <= d;
    do @(posedge sys_clk); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
    if (w) @(posedge sys_clk);
  endtask
  task automatic say(input string s);
    for (int i = 0; i < s.len(); i++) host.put(s[i]);
  endtask
  task automatic rx_wait(input int n);
    while (host.rxq.size() < n) @(posedge sys_clk);
  endtask
  // Model of STATUS from expected mode, cutoff, enables and states
  function automatic logic [31:0] mst(int bin, int cut, int en, int st);
    return 32'((st << 5) | (en << 2) | (cut << 1) | bin);
  endfunction
  initial begin
    void'($urandom(32'h1a11_1652));
    rst = 1'b1;
    req = '0;
    req.hready = rsp.hreadyout;
    req.hsel = 1'b1;
    req.hsize = 3'b010;
    meas = '0;
    meas.vin = 16'($urandom_range(16'h0FFF, 16'h0500));
    meas.iout[1] = 16'($urandom_range(16'h0060));
    meas.iout[2] = 16'($urandom_range(16'h0060));
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    bus(0, 8'h00, 0); chk(rd, 32'h0000_0000);
    bus(0, 8'h04, 0); chk(rd, mst(0, 0, 0, 0));
    bus(0, 8'h10, 0); chk(rd, 32'h01F4_01F4);
    bus(0, 8'h20, 0); chk(rd, 32'h0000_09C4);
    bus(0, 8'h3C, 0); chk(rd, 32'h0000_0000);
    bus(1, 8'h0C, 32'h0000_000D);
    host.rxq.delete();
    say("en 1\015");
    rx_wait(68);
    chk(out_en, 3'b001);
    chk(host.rxq[0], "I");
    chk({host.rxq[6], host.rxq[7]}, 16'h0D0A);
    chk({host.rxq[8], host.rxq[25], host.rxq[45]}, {"1", "V", "O"});
    host.rxq.delete();
    say(":q\015");
    rx_wait(68);
    bus(0, 8'h04, 0); chk(rd, mst(0, 0, 1, 1));
    host.rxq.delete();
    say(":b\015");
    repeat (8) @(posedge sys_clk);
    bus(0, 8'h04, 0); chk(rd, mst(1, 0, 1, 1));
    chk(irq, 1'b1);
    bus(0, 8'h08, 0); chk(rd, 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
    rx_wait(25);
    t1 = cyc;
    sum = 16'h0000;
    for (int i = 0; i < 23; i++) sum += 16'(host.rxq[i]);
    chk({host.rxq[0], host.rxq[1], host.rxq[2]}, "snp");
    chk({host.rxq[3], host.rxq[4]}, 16'hC855);
    chk({host.rxq[23], host.rxq[24]}, sum);
    rx_wait(50);
    chk((cyc - t1 >= SD - 1) && (cyc - t1 <= SD + 1), 1'b1);
    say(":x");
    repeat (8) @(posedge sys_clk);
    bus(0, 8'h04, 0); chk(rd, mst(0, 0, 1, 1));
    chk(irq, 1'b0);
    bus(0, 8'h08, 0); chk(rd, 32'h0000_0002);
    bus(0, 8'h08, 0); chk(rd, 32'h0000_0000);
    meas.iout[0] <= 16'h0070;
    m_ctrl = 32'h0000_0041;
    bus(1, 8'h00, m_ctrl);
    repeat (400) @(posedge sys_clk);
    chk(out_state[0], smc_pkg::SMC_CURRENT_REGULATING);
    chk(out_vset[0] < 16'h01F4, 1'b1);
    chk(irq, 1'b1);
    bus(0, 8'h08, 0); chk(rd, 32'h0000_0008);
    v1 = out_vset[0];
    m_ctrl = 32'h0000_0001;
    bus(1, 8'h00, m_ctrl);
    repeat (800) @(posedge sys_clk);
    chk(out_state[0], smc_pkg::SMC_VOLTAGE_REGULATING);
    chk(out_vset[0] > v1, 1'b1);
    host.rxq.delete();
    say("set1 5.5\015");
    say("setc2 1.0\015");
    repeat (4) @(posedge sys_clk);
    bus(0, 8'h10, 0); chk(rd[15:0], 16'h0226);
    bus(0, 8'h24, 0); chk(rd, {meas.iout[1], 16'h03E8});
    rx_wait(68);
    bus(0, 8'h08, 0); chk(rd, 32'h0000_0008);
    meas.vin <= 16'h0400;
    m_ctrl = 32'h0400_0227;
    bus(1, 8'h00, m_ctrl);
    repeat (4) @(posedge sys_clk);
    chk({sleep, out_en}, 4'b0111);
    meas.vin <= 16'h03FF;
    repeat (4) @(posedge sys_clk);
    chk({sleep, out_en}, 4'b1100);
    bus(0, 8'h04, 0); chk(rd, mst(0, 1, 4, 16));
    chk(irq, 1'b1);
    bus(0, 8'h08, 0); chk(rd, 32'h0000_0004);
    meas.vin <= 16'h0500;
    repeat (10) @(posedge sys_clk);
    chk({sleep, out_en}, 4'b1100);
    host.rxq.delete();
    say("dis 3\015");
    rx_wait(68);
    chk(out_en, 3'b000);
    bus(0, 8'h00, 0); chk(rd, m_ctrl & 32'hFFFF_FFFB);
    chk(host.bad_stop, 0);
    end_sim();
  end
endmodule
